/* File: verilog/srw_defines.vh */
// constants for the supervisor reset watchdog
// Summary of operation
// - low manual reset input triggers reset
// - undriven manual reset reads as inactive high
// - supply fail output follows sense input
// - idle kick beyond timeout drives timeout low
// - any kick edge clears watchdog counter
// - counter held clear while reset asserted
// - floating kick input disables the watchdog
// - any trigger gives a reset pulse of at least the fixed width
// - reset held low while supply is low
// - full pulse width after trigger releases
// - timeout never asserts reset by itself
// - timeout output stays low until cleared
// - low supply forces timeout output low
// - supply recovery returns timeout output high
// - active-high reset is complement of reset only when built without watchdog, held low otherwise
// - watchdog timing starts after reset releases
`ifndef SRW_DEFINES_VH
`define SRW_DEFINES_VH
`define SRW_CLK_MHZ 250
`define SRW_PULSE_MS 200
`define SRW_TIMEOUT_MS 1600
`define SRW_PULSE_CYC (`SRW_PULSE_MS * 1000 * `SRW_CLK_MHZ)
`define SRW_TIMEOUT_CYC (`SRW_TIMEOUT_MS * 1000 * `SRW_CLK_MHZ)
`define SRW_CNT_W 32
`define SRW_SYNC_W 2
`endif

/* File: verilog/srw_sync.v */
// two-flop synchroniser for one level input
`timescale 1ns/1ps
module srw_sync #(
	parameter RESET_VAL = 1'b0
) (
	input wire core_clk_i,
	input wire sys_rst_i,
	input wire d_i,
	output reg q_o
);
	reg meta_r;
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta_r <= RESET_VAL;
			q_o <= RESET_VAL;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule // srw_sync

/* File: verilog/srw_top.v */
// supervisor: reset pulse stretcher, watchdog and supply-fail flag
`timescale 1ns/1ps
`include "srw_defines.vh"
module srw_top #(
	parameter HAS_WATCHDOG = 1,
	parameter [31:0] PULSE_CYC = `SRW_PULSE_CYC,
	parameter [31:0] TIMEOUT_CYC = `SRW_TIMEOUT_CYC
) (
	input wire core_clk_i,
	input wire sys_rst_i,
	input wire supply_low_i,
	input wire manual_reset_n_i,
	input wire manual_reset_driven_i,
	input wire supply_sense_in_i,
	input wire kick_in_i,
	input wire kick_in_driven_i,
	output reg reset_n_o,
	output reg reset_o,
	output reg supply_fail_n_o,
	output reg kick_timeout_n_o
);
	wire supply_low_s;
	wire mr_n_s;
	wire mr_drv_s;
	wire sense_s;
	wire kick_s;
	wire kick_drv_s;
	reg kick_d_r;
	reg [`SRW_CNT_W-1:0] pulse_cnt_r;
	reg [`SRW_CNT_W-1:0] wd_cnt_r;
	reg wd_expired_r;
	wire mr_low;
	wire trigger;
	wire kick_edge;
	wire wd_enable;

	srw_sync #(.RESET_VAL(1'b1)) u_sync_vlow (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.d_i(supply_low_i), .q_o(supply_low_s));
	srw_sync #(.RESET_VAL(1'b1)) u_sync_mr (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.d_i(manual_reset_n_i), .q_o(mr_n_s));
	srw_sync #(.RESET_VAL(1'b0)) u_sync_mrd (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.d_i(manual_reset_driven_i), .q_o(mr_drv_s));
	srw_sync #(.RESET_VAL(1'b1)) u_sync_pfi (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.d_i(supply_sense_in_i), .q_o(sense_s));
	srw_sync #(.RESET_VAL(1'b0)) u_sync_kick (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.d_i(kick_in_i), .q_o(kick_s));
	srw_sync #(.RESET_VAL(1'b0)) u_sync_kdrv (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.d_i(kick_in_driven_i), .q_o(kick_drv_s));

	// low level triggers, undriven pin is pulled high
	assign mr_low = mr_drv_s & ~mr_n_s;
	// only supply and manual reset trigger
	assign trigger = supply_low_s | mr_low;
	// watchdog only when built in and pin driven
	assign wd_enable = (HAS_WATCHDOG != 0) & kick_drv_s;
	assign kick_edge = kick_s ^ kick_d_r;

	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			kick_d_r <= 1'b0;
		end else begin
			kick_d_r <= kick_s;
		end
	end

	// pulse timer restarts while triggered, expires after PULSE_CYC
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pulse_cnt_r <= 32'h00000000;
			reset_n_o <= 1'b0;
			// complement holds during core reset only when built without watchdog, held low otherwise
			reset_o <= (HAS_WATCHDOG == 0);
		end else begin
			if (trigger) begin
				pulse_cnt_r <= 32'h00000000;
				reset_n_o <= 1'b0;
			end else if (pulse_cnt_r < PULSE_CYC - 32'h00000001) begin
				pulse_cnt_r <= pulse_cnt_r + 32'h00000001;
				reset_n_o <= 1'b0;
			end else begin
				reset_n_o <= 1'b1;
			end
			// complement, held low when the variant lacks it
			if (HAS_WATCHDOG == 0) begin
				reset_o <= trigger | (pulse_cnt_r < PULSE_CYC - 32'h00000001);
			end else begin
				reset_o <= 1'b0;
			end
		end
	end

	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			supply_fail_n_o <= 1'b1;
		end else begin
			supply_fail_n_o <= sense_s;
		end
	end

	// watchdog counter and sticky expiry
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wd_cnt_r <= 32'h00000000;
			wd_expired_r <= 1'b0;
		end else if (!reset_n_o || !wd_enable || kick_edge) begin
			// cleared during reset; cleared on kick edge
			wd_cnt_r <= 32'h00000000;
			wd_expired_r <= 1'b0;
		end else if (wd_cnt_r < TIMEOUT_CYC - 32'h00000001) begin
			wd_cnt_r <= wd_cnt_r + 32'h00000001;
		end else begin
			wd_expired_r <= 1'b1;
		end
	end

	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			kick_timeout_n_o <= 1'b1;
		end else if (HAS_WATCHDOG == 0) begin
			kick_timeout_n_o <= 1'b1;
		end else begin
			// low supply forces low, follows timer otherwise
			kick_timeout_n_o <= ~(supply_low_s | wd_expired_r);
		end
	end
endmodule // srw_top

/* File: tb/srw_host.sv */
// host model that toggles the kick line
`timescale 1ns/1ps
module srw_host (
	input wire core_clk_i,
	input wire kick_en_i,
	output reg kick_o
);
	reg [2:0] tick_r = 3'h0;
	initial kick_o = 1'b0;
	reg en_r = 1'b0;
	// enable is sampled on the rising edge so it never races the bench
	always @(posedge core_clk_i) begin
		en_r <= kick_en_i;
	end
	always @(negedge core_clk_i) begin
		tick_r <= tick_r + 3'h1;
		if (en_r && tick_r == 3'h0) begin
			kick_o <= ~kick_o;
		end
	end
endmodule // srw_host

/* File: tb/srw_top_monitor.sv */
// assertions on the supervisor ports
`timescale 1ns/1ps
module srw_monitor (
	input wire core_clk_i,
	input wire sys_rst_i,
	input wire supply_low_i,
	input wire manual_reset_n_i,
	input wire manual_reset_driven_i,
	input wire supply_sense_in_i,
	input wire kick_in_i,
	input wire kick_in_driven_i,
	input wire reset_n_o,
	input wire reset_o,
	input wire supply_fail_n_o,
	input wire kick_timeout_n_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_calm; (reset_n_o && manual_reset_n_i && !supply_low_i)[*6]; endsequence
	sequence s_kick; $changed(kick_in_i) ##1 (kick_in_driven_i && !supply_low_i)[*6]; endsequence
	a_manual_low: assert property ($fell(manual_reset_n_i) && manual_reset_driven_i |-> ##[1:4] !reset_n_o)
		else $error("no reset");
	a_fail_low: assert property ($fell(supply_sense_in_i) |-> ##[1:4] !supply_fail_n_o)
		else $error("fail late");
	a_fail_high: assert property ($rose(supply_sense_in_i) |-> ##[1:4] supply_fail_n_o)
		else $error("ok late");
	a_supply_hold: assert property (supply_low_i [*5] |-> !reset_n_o)
		else $error("reset high");
	a_supply_to: assert property (supply_low_i [*5] |-> !kick_timeout_n_o)
		else $error("timeout high");
	a_pulse_min: assert property ($rose(reset_n_o) |-> !$past(reset_n_o, 18))
		else $error("short pulse");
	a_no_wd_rst: assert property (s_calm ##0 $fell(kick_timeout_n_o) |=> reset_n_o)
		else $error("timeout reset");
	a_kick_clear: assert property (s_kick |-> kick_timeout_n_o)
		else $error("kick lost");
	a_high_reset: assert property (reset_o |-> !reset_n_o)
		else $error("high reset while released");
endmodule // srw_monitor
bind srw_top srw_monitor u_mon (.core_clk_i, .sys_rst_i, .supply_low_i, .manual_reset_n_i,
	.manual_reset_driven_i, .supply_sense_in_i, .kick_in_i, .kick_in_driven_i, .reset_n_o,
	.reset_o, .supply_fail_n_o, .kick_timeout_n_o);

/* File: tb/srw_top_tb.sv */
// bench for the supervisor top
`timescale 1ns/1ps
module srw_top_tb;
	reg clk = 0, rst = 1, sl = 1, mr = 1, md = 1, ss = 1, kd = 1, ke = 0;
	wire kick, rn, rh, pf, to;
	integer err_count = 0, cmp_count = 0, cyc = 0;
	always #2 clk = ~clk;
	srw_host u_host (.core_clk_i(clk), .kick_en_i(ke), .kick_o(kick));
	srw_top #(.PULSE_CYC(20), .TIMEOUT_CYC(50)) u_dut (.core_clk_i(clk), .sys_rst_i(rst),
		.supply_low_i(sl), .manual_reset_n_i(mr), .manual_reset_driven_i(md),
		.supply_sense_in_i(ss), .kick_in_i(kick), .kick_in_driven_i(kd),
		.reset_n_o(rn), .reset_o(rh), .supply_fail_n_o(pf), .kick_timeout_n_o(to));
	task w(input integer n); repeat (n) @(negedge clk); endtask
	task c(input logic v);
		begin
			cmp_count = cmp_count + 1;
			if (v !== 1'b1) begin
				err_count = err_count + 1;
				$display("[ERR] %0t mismatch", $time);
			end
		end
	endtask
	task complete_run;
		begin
			$display("errors %0d checks %0d", err_count, cmp_count);
			if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
			else $display("SIMULATION FAILED");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count = err_count + 1;
			complete_run;
		end
	end
	initial begin
		w(12);
		rst = 0;
		w(2);
		c(rh === 1'b0);
		c(rn === 1'b0);
		c(to === 1'b0);
		sl = 0;
		w(6);
		c(to === 1'b1);
		w(10);
		c(rn === 1'b0);
		w(12);
		c(rn === 1'b1);
		mr = 0;
		w(5);
		c(rn === 1'b0);
		mr = 1;
		w(16);
		c(rn === 1'b0);
		w(12);
		c(rn === 1'b1);
		ke = 1;
		w(200);
		c(to === 1'b1);
		ke = 0;
		w(70);
		c(to === 1'b0);
		c(rn === 1'b1);
		w(30);
		c(to === 1'b0);
		ke = 1;
		w(16);
		ke = 0;
		w(6);
		c(to === 1'b1);
		kd = 0;
		md = 0;
		mr = 0;
		w(120);
		c(to === 1'b1);
		c(rn === 1'b1);
		md = 1;
		mr = 1;
		kd = 1;
		ss = 0;
		w(5);
		c(pf === 1'b0);
		ss = 1;
		w(5);
		c(pf === 1'b1);
		complete_run;
	end
endmodule // srw_top_tb
